// *** flash_ctrl_pkg.sv ***
// Package: register map, field positions, reset values and bus codes of the
// flash program/erase control block.
// Assumes a 32-bit AXI4-Lite register bus and one 25 MHz clock.
package flash_ctrl_pkg;

	// Register byte addresses (own choice, one aligned word each)
	localparam logic [3:0] ADDR_MODE_CTRL_ONE = 4'h0;
	localparam logic [3:0] ADDR_MODE_CTRL_TWO = 4'h4;
	localparam logic [3:0] ADDR_SYS_STATE     = 4'h8;

	// Control register one fields
	localparam int HW_GATE_BIT    = 7;
	localparam int SOFT_GATE_BIT  = 6;
	localparam int ERASE_CHK_BIT  = 3;
	localparam int WRITE_CHK_BIT  = 2;
	localparam int ERASE_GO_BIT   = 1;
	localparam int WRITE_GO_BIT   = 0;

	// Control register two fields
	localparam int FAULT_BIT      = 7;
	localparam int ERASE_PREP_BIT = 1;
	localparam int WRITE_PREP_BIT = 0;

	// System state register fields (standby and flash-disabled inputs, read only)
	localparam int SW_STBY_BIT    = 0;
	localparam int HW_STBY_BIT    = 1;
	localparam int FLASH_OFF_BIT  = 2;

	// Reset and read values
	localparam logic [7:0] REG_ZERO      = 8'h00;
	localparam logic [7:0] ONE_RESET_HI  = 8'h80;

	// Operating modes in which on-chip flash is disabled
	localparam logic [3:0] MODE_NO_FLASH_A = 4'h4;
	localparam logic [3:0] MODE_NO_FLASH_B = 4'h5;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Write access takes two states: one wait state after address and data meet
	localparam int ACCESS_STATES = 2;

	// Write decoder bank size
	localparam int CTRL_BITS = 8;

endpackage : flash_ctrl_pkg

// *** write_gate_logic.sv ***
// Write gating for the flash control bits: decides per bit whether a
// software write may change it, given the current protection state.
// Assumes it is fed the registered bit values and the pin level.
`timescale 1ns/10ps
module write_gate_logic
	import flash_ctrl_pkg::*;
(
	input  wire logic                 hw_gate_i,
	input  wire logic                 soft_gate_i,
	input  wire logic                 erase_prep_i,
	input  wire logic                 write_prep_i,
	input  wire logic                 fault_i,
	output logic [CTRL_BITS-1:0]      one_mask_o,
	output logic [CTRL_BITS-1:0]      two_mask_o
);

	//------------------------------------------------------------
	// Enable terms
	//------------------------------------------------------------
	logic both_gates;
	logic [CTRL_BITS-1:0] one_need;

	// Error protection also blocks the go bits
	always_comb
	begin
		both_gates = hw_gate_i & soft_gate_i;
		one_need                = '0;
		one_need[SOFT_GATE_BIT] = hw_gate_i;
		one_need[ERASE_CHK_BIT] = both_gates;
		one_need[WRITE_CHK_BIT] = both_gates;
		one_need[ERASE_GO_BIT]  = both_gates & erase_prep_i & ~fault_i;
		one_need[WRITE_GO_BIT]  = both_gates & write_prep_i & ~fault_i;
	end

	// One mask bit per field; reserved and read-only bits stay zero
	genvar gi;
	generate
		for (gi = 0; gi < CTRL_BITS; gi++)
		begin : g_mask
			assign one_mask_o[gi] = one_need[gi];
			assign two_mask_o[gi] = ((gi == ERASE_PREP_BIT) || (gi == WRITE_PREP_BIT))
				? (both_gates & ~fault_i) : 1'b0;
		end
	endgenerate

endmodule : write_gate_logic

// *** bus_slave_lite.sv ***
// AXI4-Lite slave front end: takes write address and data in either order,
// inserts one wait state, and returns a byte-wide register access.
// Assumes one outstanding write and one outstanding read from the master.
`timescale 1ns/10ps
module bus_slave_lite
	import flash_ctrl_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  awaddr_i,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	output logic [1:0]       bresp_o,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	input  wire logic [3:0]  araddr_i,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	output logic             wr_pulse_o,
	output logic [3:0]       wr_addr_o,
	output logic [7:0]       wr_data_o,
	output logic [3:0]       rd_addr_o,
	input  wire logic [7:0]  rd_data_i,
	input  wire logic        rd_ok_i,
	input  wire logic        wr_ok_i
);

	typedef struct packed {
		logic        aw_got;
		logic        w_got;
		logic [3:0]  waddr;
		logic [7:0]  wdata;
		logic        wbyte;
		logic        wwait;
		logic        wr_pulse;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        ar_got;
		logic [3:0]  raddr;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} slave_state_type;

	slave_state_type st_ff;
	slave_state_type nxt_st;

	//------------------------------------------------------------
	// Channel handling
	//------------------------------------------------------------
	// Only byte lane 0 may be written: byte access only
	always_comb
	begin
		nxt_st          = st_ff;
		nxt_st.wr_pulse = 1'b0;
		if (awvalid_i && !st_ff.aw_got && !st_ff.bvalid)
		begin
			nxt_st.aw_got = 1'b1;
			nxt_st.waddr  = awaddr_i;
		end
		if (wvalid_i && !st_ff.w_got && !st_ff.bvalid)
		begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = wdata_i[7:0];
			nxt_st.wbyte = (wstrb_i == 4'h1);
		end
		// Wait state so every write access spans two states
		if (st_ff.aw_got && st_ff.w_got && !st_ff.wwait)
		begin
			nxt_st.wwait = 1'b1;
		end
		if (st_ff.wwait)
		begin
			nxt_st.wwait    = 1'b0;
			nxt_st.aw_got   = 1'b0;
			nxt_st.w_got    = 1'b0;
			nxt_st.wr_pulse = st_ff.wbyte & wr_ok_i;
			nxt_st.bvalid   = 1'b1;
			nxt_st.bresp    = (st_ff.wbyte && wr_ok_i) ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_ff.bvalid && bready_i)
		begin
			nxt_st.bvalid = 1'b0;
		end
		// Read: address taken, data returned next cycle
		if (arvalid_i && !st_ff.ar_got && !st_ff.rvalid)
		begin
			nxt_st.ar_got = 1'b1;
			nxt_st.raddr  = araddr_i;
		end
		if (st_ff.ar_got)
		begin
			nxt_st.ar_got = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = {24'h000000, rd_data_i};
			nxt_st.rresp  = rd_ok_i ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_ff.rvalid && rready_i)
		begin
			nxt_st.rvalid = 1'b0;
		end
	end

	// State register
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign awready_o  = ~st_ff.aw_got & ~st_ff.bvalid;
	assign wready_o   = ~st_ff.w_got & ~st_ff.bvalid;
	assign bvalid_o   = st_ff.bvalid;
	assign bresp_o    = st_ff.bresp;
	assign arready_o  = ~st_ff.ar_got & ~st_ff.rvalid;
	assign rvalid_o   = st_ff.rvalid;
	assign rresp_o    = st_ff.rresp;
	assign rdata_o    = st_ff.rdata;
	assign wr_pulse_o = st_ff.wr_pulse;
	assign wr_addr_o  = st_ff.waddr;
	assign wr_data_o  = st_ff.wdata;
	assign rd_addr_o  = st_ff.raddr;

endmodule : bus_slave_lite

// *** flash_prog_erase_control.sv ***
// Flash program/erase control: two byte-wide mode control registers with
// hardware/software write gating, setup bits, sticky fault flag and
// standby handling, reached over AXI4-Lite.
// Assumes pin, mode and standby inputs are synchronous to sys_clk_i.
`timescale 1ns/10ps
module flash_prog_erase_control
	import flash_ctrl_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        hw_write_gate_i,
	input  wire logic [3:0]  op_mode_i,
	input  wire logic        hw_standby_i,
	input  wire logic        sw_standby_i,
	input  wire logic        op_fail_i,
	input  wire logic        flash_reg_select_i,
	input  wire logic [3:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [3:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic             write_mode_o,
	output logic             erase_mode_o,
	output logic             write_check_mode_o,
	output logic             erase_check_mode_o,
	output logic             flash_fault_flag_o,
	output logic             write_allowed_o
);

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef struct packed {
		logic hw_write_gate;
		logic soft_write_gate;
		logic erase_check_mode;
		logic write_check_mode;
		logic erase_go;
		logic write_go;
		logic flash_fault_flag;
		logic erase_prep;
		logic write_prep;
	} ctrl_state_type;

	ctrl_state_type st_ff;
	ctrl_state_type nxt_st;

	logic             wr_pulse;
	logic [3:0]       wr_addr;
	logic [7:0]       wr_data;
	logic [3:0]       rd_addr;
	logic [7:0]       rd_data;
	logic             rd_ok;
	logic             wr_ok;
	logic             flash_off;
	logic [CTRL_BITS-1:0] one_mask;
	logic [CTRL_BITS-1:0] two_mask;
	logic [7:0]       reg_one;
	logic [7:0]       reg_two;
	logic [7:0]       sys_state;

	//------------------------------------------------------------
	// Submodules
	//------------------------------------------------------------
	bus_slave_lite u_bus (
		.sys_clk_i  (sys_clk_i),
		.rst_n_i    (rst_n_i),
		.awaddr_i   (s_axi_awaddr_i),
		.awvalid_i  (s_axi_awvalid_i),
		.awready_o  (s_axi_awready_o),
		.wdata_i    (s_axi_wdata_i),
		.wstrb_i    (s_axi_wstrb_i),
		.wvalid_i   (s_axi_wvalid_i),
		.wready_o   (s_axi_wready_o),
		.bresp_o    (s_axi_bresp_o),
		.bvalid_o   (s_axi_bvalid_o),
		.bready_i   (s_axi_bready_i),
		.araddr_i   (s_axi_araddr_i),
		.arvalid_i  (s_axi_arvalid_i),
		.arready_o  (s_axi_arready_o),
		.rdata_o    (s_axi_rdata_o),
		.rresp_o    (s_axi_rresp_o),
		.rvalid_o   (s_axi_rvalid_o),
		.rready_i   (s_axi_rready_i),
		.wr_pulse_o (wr_pulse),
		.wr_addr_o  (wr_addr),
		.wr_data_o  (wr_data),
		.rd_addr_o  (rd_addr),
		.rd_data_i  (rd_data),
		.rd_ok_i    (rd_ok),
		.wr_ok_i    (wr_ok)
	);

	write_gate_logic u_gate (
		.hw_gate_i    (st_ff.hw_write_gate),
		.soft_gate_i  (st_ff.soft_write_gate),
		.erase_prep_i (st_ff.erase_prep),
		.write_prep_i (st_ff.write_prep),
		.fault_i      (st_ff.flash_fault_flag),
		.one_mask_o   (one_mask),
		.two_mask_o   (two_mask)
	);

	//------------------------------------------------------------
	// Register views
	//------------------------------------------------------------
	// Disabled-flash modes hide both registers
	always_comb
	begin
		flash_off = (op_mode_i == MODE_NO_FLASH_A) || (op_mode_i == MODE_NO_FLASH_B);
		reg_one   = REG_ZERO;
		reg_one[HW_GATE_BIT]   = st_ff.hw_write_gate;
		reg_one[SOFT_GATE_BIT] = st_ff.soft_write_gate;
		reg_one[ERASE_CHK_BIT] = st_ff.erase_check_mode;
		reg_one[WRITE_CHK_BIT] = st_ff.write_check_mode;
		reg_one[ERASE_GO_BIT]  = st_ff.erase_go;
		reg_one[WRITE_GO_BIT]  = st_ff.write_go;
		reg_two = REG_ZERO;
		reg_two[FAULT_BIT]      = st_ff.flash_fault_flag;
		reg_two[ERASE_PREP_BIT] = st_ff.erase_prep;
		reg_two[WRITE_PREP_BIT] = st_ff.write_prep;
		sys_state = REG_ZERO;
		sys_state[SW_STBY_BIT]   = sw_standby_i;
		sys_state[HW_STBY_BIT]   = hw_standby_i;
		sys_state[FLASH_OFF_BIT] = flash_off;
		// Unmapped write addresses get an error response, not a silent drop
		wr_ok = (wr_addr == ADDR_MODE_CTRL_ONE) || (wr_addr == ADDR_MODE_CTRL_TWO) ||
			(wr_addr == ADDR_SYS_STATE);
		rd_ok   = 1'b1;
		rd_data = REG_ZERO;
		case (rd_addr)
			ADDR_MODE_CTRL_ONE: rd_data = flash_off ? REG_ZERO : reg_one;
			ADDR_MODE_CTRL_TWO: rd_data = flash_off ? REG_ZERO : reg_two;
			ADDR_SYS_STATE:     rd_data = sys_state;
			default:            rd_ok   = 1'b0;
		endcase
	end

	//------------------------------------------------------------
	// Control bit update
	//------------------------------------------------------------
	// Writes land only where the gate mask allows; the fault set wins
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.hw_write_gate = hw_write_gate_i;
		if (wr_pulse && !flash_off && flash_reg_select_i)
		begin
			if (wr_addr == ADDR_MODE_CTRL_ONE)
			begin
				if (one_mask[SOFT_GATE_BIT])
					nxt_st.soft_write_gate = wr_data[SOFT_GATE_BIT];
				if (one_mask[ERASE_CHK_BIT])
					nxt_st.erase_check_mode = wr_data[ERASE_CHK_BIT];
				if (one_mask[WRITE_CHK_BIT])
					nxt_st.write_check_mode = wr_data[WRITE_CHK_BIT];
				if (one_mask[ERASE_GO_BIT])
					nxt_st.erase_go = wr_data[ERASE_GO_BIT];
				if (one_mask[WRITE_GO_BIT])
					nxt_st.write_go = wr_data[WRITE_GO_BIT];
			end
			else if (wr_addr == ADDR_MODE_CTRL_TWO)
			begin
				if (two_mask[ERASE_PREP_BIT])
					nxt_st.erase_prep = wr_data[ERASE_PREP_BIT];
				if (two_mask[WRITE_PREP_BIT])
					nxt_st.write_prep = wr_data[WRITE_PREP_BIT];
			end
		end
		// Sticky fault: no write path clears it
		if (op_fail_i && (st_ff.write_go || st_ff.erase_go))
			nxt_st.flash_fault_flag = 1'b1;
		if (st_ff.flash_fault_flag || nxt_st.flash_fault_flag)
		begin
			nxt_st.write_go   = 1'b0;
			nxt_st.erase_go   = 1'b0;
		end
		// Protection or software standby drops the prep bits
		if (sw_standby_i || !hw_write_gate_i || !nxt_st.soft_write_gate)
		begin
			nxt_st.erase_prep = 1'b0;
			nxt_st.write_prep = 1'b0;
		end
		// Pin low or soft gate low: nothing may write or erase
		if (!hw_write_gate_i || !nxt_st.soft_write_gate)
		begin
			nxt_st.write_go = 1'b0;
			nxt_st.erase_go = 1'b0;
		end
		// Standby reinitialises register one to the pin level
		if (sw_standby_i || hw_standby_i)
		begin
			nxt_st.soft_write_gate  = 1'b0;
			nxt_st.erase_check_mode = 1'b0;
			nxt_st.write_check_mode = 1'b0;
			nxt_st.write_go         = 1'b0;
			nxt_st.erase_go         = 1'b0;
		end
		if (hw_standby_i)
		begin
			nxt_st.flash_fault_flag = 1'b0;
			nxt_st.erase_prep       = 1'b0;
			nxt_st.write_prep       = 1'b0;
		end
	end

	// State register; the pin is caught on the first edge after release
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	//------------------------------------------------------------
	// Outputs, all from flip-flops
	//------------------------------------------------------------
	assign write_mode_o       = st_ff.write_go;
	assign erase_mode_o       = st_ff.erase_go;
	assign write_check_mode_o = st_ff.write_check_mode;
	assign erase_check_mode_o = st_ff.erase_check_mode;
	assign flash_fault_flag_o = st_ff.flash_fault_flag;
	assign write_allowed_o    = st_ff.soft_write_gate;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	a_pin_tracks: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$past(rst_n_i) |-> st_ff.hw_write_gate == $past(hw_write_gate_i))
		else $error("pin status lags");
	a_soft_blocked: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(st_ff.soft_write_gate) |-> $past(st_ff.hw_write_gate))
		else $error("soft gate set, pin low");
	a_check_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(st_ff.write_check_mode) |-> $past(st_ff.soft_write_gate && st_ff.hw_write_gate))
		else $error("check bit set without gates");
	a_erase_go: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(st_ff.erase_go) |-> $past(st_ff.erase_prep)) else $error("erase go without prep");
	a_write_go: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(st_ff.write_go) |-> $past(st_ff.write_prep)) else $error("write go without prep");
	a_off_reads: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		flash_off && rd_addr == ADDR_MODE_CTRL_ONE |-> rd_data == REG_ZERO)
		else $error("disabled read not zero");
	a_prep_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		sw_standby_i |=> !st_ff.erase_prep && !st_ff.write_prep) else $error("prep kept in standby");
	a_fault_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		st_ff.flash_fault_flag && !hw_standby_i |=> st_ff.flash_fault_flag)
		else $error("fault flag cleared");
	a_no_write_go: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!st_ff.soft_write_gate |-> !st_ff.write_go && !st_ff.erase_go) else $error("go without gate");
	a_erase_chk_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(st_ff.erase_check_mode) |-> $past(st_ff.soft_write_gate && st_ff.hw_write_gate))
		else $error("erase check set without gates");
	a_prep_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(st_ff.write_prep) |-> $past(st_ff.soft_write_gate && st_ff.hw_write_gate))
		else $error("prep set without gates");
	a_fault_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		op_fail_i && (st_ff.write_go || st_ff.erase_go) && !hw_standby_i
		|=> st_ff.flash_fault_flag) else $error("fault flag not set");
	a_hard_stby: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		hw_standby_i |=> !st_ff.flash_fault_flag && !st_ff.erase_prep && !st_ff.write_prep)
		else $error("register two kept in standby");

	c_write_mode: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(st_ff.write_go));
	c_erase_mode: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(st_ff.erase_go));
	c_fault:      cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(st_ff.flash_fault_flag));
	c_write_check: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(st_ff.write_check_mode));
	c_erase_check: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(st_ff.erase_check_mode));

endmodule : flash_prog_erase_control

// *** flash_prog_erase_control_bench.sv ***
// Self-checking bench for the flash program/erase control block.
// Assumes the design package and design sources are compiled before it.
`timescale 1ns/10ps
module flash_prog_erase_control_bench
	import flash_ctrl_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus signals
	// ------------------------------------------------------------
	logic        clk = 1'b0, rst_n = 1'b0, pin = 1'b1, sel = 1'b1;
	logic        hstby = 1'b0, sstby = 1'b0, fail = 1'b0;
	logic [3:0]  mode = 4'he, awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, r;
	logic        wm, em, wcm, ecm, fault, allowed;
	int          err_count = 0, checks_done = 0;

	// 25 MHz clock
	always #20 clk = ~clk;

	flash_prog_erase_control dut_u (.sys_clk_i(clk), .rst_n_i(rst_n),
		.hw_write_gate_i(pin), .op_mode_i(mode), .hw_standby_i(hstby),
		.sw_standby_i(sstby), .op_fail_i(fail), .flash_reg_select_i(sel),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .write_mode_o(wm),
		.erase_mode_o(em), .write_check_mode_o(wcm), .erase_check_mode_o(ecm),
		.flash_fault_flag_o(fault), .write_allowed_o(allowed));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// Payload is inverted on release so a stale value is never mistaken for data
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] rsp);
		int n;
		logic ad, wd;
		n = 0;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (!ad && awready === 1'b1)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (!wd && wready === 1'b1)
			begin
				wd = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end while (!(ad && wd && bvalid === 1'b1) && n < 40);
		rsp = bresp;
		bready <= 1'b0;
		chk(n < 40, 1'b1, "write answer");
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		int n;
		logic ad;
		n = 0;
		ad = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (!ad && arready === 1'b1)
			begin
				ad = 1'b1;
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end while (!(ad && rvalid === 1'b1) && n < 40);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		chk(n < 40, 1'b1, "read answer");
	endtask : rd

	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		logic [1:0] rsp;
		wr(a, {24'h0, d}, 4'h1, rsp);
		chk(rsp, RESP_OKAY, "byte write response");
		// Register bits change on the edge that ends the response; look after it
		cyc(1);
	endtask : wr8

	task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string what);
		logic [31:0] d;
		rd(a, d);
		chk(d, {24'h0, e}, what);
		chk(r, RESP_OKAY, "read response");
	endtask : rdc

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_gates();
		rdc(ADDR_MODE_CTRL_ONE, 8'h80, "one after reset");
		rdc(ADDR_MODE_CTRL_TWO, 8'h00, "two after reset");
		pin <= 1'b0;
		cyc(2);
		wr8(ADDR_MODE_CTRL_ONE, 8'h40);
		rdc(ADDR_MODE_CTRL_ONE, 8'h00, "gate refused, pin low");
		pin <= 1'b1;
		cyc(2);
		wr8(ADDR_MODE_CTRL_ONE, 8'h30);
		rdc(ADDR_MODE_CTRL_ONE, 8'h80, "reserved bits one");
		wr8(ADDR_MODE_CTRL_ONE, 8'h40);
		rdc(ADDR_MODE_CTRL_ONE, 8'hc0, "gate set");
		chk(allowed, 1'b1, "writing allowed");
	endtask : t_gates

	task automatic t_checks();
		wr8(ADDR_MODE_CTRL_ONE, 8'h44);
		chk(wcm, 1'b1, "write check entered");
		wr8(ADDR_MODE_CTRL_ONE, 8'h40);
		chk(wcm, 1'b0, "write check left");
		wr8(ADDR_MODE_CTRL_ONE, 8'h48);
		rdc(ADDR_MODE_CTRL_ONE, 8'hc8, "erase check held");
		chk(ecm, 1'b1, "erase check entered");
		wr8(ADDR_MODE_CTRL_ONE, 8'h40);
		chk(ecm, 1'b0, "erase check left");
		wr8(ADDR_MODE_CTRL_ONE, 8'h00);
		chk(allowed, 1'b0, "writing blocked");
		wr8(ADDR_MODE_CTRL_ONE, 8'h04);
		rdc(ADDR_MODE_CTRL_ONE, 8'h80, "check refused without gate");
	endtask : t_checks

	task automatic t_go();
		wr8(ADDR_MODE_CTRL_ONE, 8'h40);
		wr8(ADDR_MODE_CTRL_ONE, 8'h41);
		rdc(ADDR_MODE_CTRL_ONE, 8'hc0, "write go refused without prep");
		wr8(ADDR_MODE_CTRL_TWO, 8'h7d);
		rdc(ADDR_MODE_CTRL_TWO, 8'h01, "write prep, reserved two");
		wr8(ADDR_MODE_CTRL_ONE, 8'h41);
		chk(wm, 1'b1, "write mode entered");
		wr8(ADDR_MODE_CTRL_ONE, 8'h40);
		chk(wm, 1'b0, "write mode left");
		wr8(ADDR_MODE_CTRL_TWO, 8'h00);
		wr8(ADDR_MODE_CTRL_ONE, 8'h42);
		rdc(ADDR_MODE_CTRL_ONE, 8'hc0, "erase go refused without prep");
		wr8(ADDR_MODE_CTRL_TWO, 8'h02);
		wr8(ADDR_MODE_CTRL_ONE, 8'h42);
		chk(em, 1'b1, "erase mode entered");
		wr8(ADDR_MODE_CTRL_ONE, 8'h40);
		chk(em, 1'b0, "erase mode left");
	endtask : t_go

	task automatic t_protect();
		pin <= 1'b0;
		cyc(2);
		rdc(ADDR_MODE_CTRL_TWO, 8'h00, "prep cleared by pin");
		pin <= 1'b1;
		cyc(2);
		wr8(ADDR_MODE_CTRL_TWO, 8'h01);
		wr8(ADDR_MODE_CTRL_ONE, 8'h00);
		rdc(ADDR_MODE_CTRL_TWO, 8'h00, "prep cleared by soft gate");
		wr8(ADDR_MODE_CTRL_ONE, 8'h40);
		wr8(ADDR_MODE_CTRL_TWO, 8'h02);
		sstby <= 1'b1;
		cyc(3);
		sstby <= 1'b0;
		cyc(2);
		rdc(ADDR_MODE_CTRL_ONE, 8'h80, "one after soft standby");
		rdc(ADDR_MODE_CTRL_TWO, 8'h00, "prep after soft standby");
	endtask : t_protect

	task automatic t_fault();
		wr8(ADDR_MODE_CTRL_ONE, 8'h40);
		wr8(ADDR_MODE_CTRL_TWO, 8'h01);
		wr8(ADDR_MODE_CTRL_ONE, 8'h41);
		fail <= 1'b1;
		cyc(1);
		fail <= 1'b0;
		cyc(2);
		chk(fault, 1'b1, "fault raised");
		chk(wm, 1'b0, "go dropped on fault");
		wr8(ADDR_MODE_CTRL_ONE, 8'h41);
		chk(wm, 1'b0, "go blocked by fault");
		wr8(ADDR_MODE_CTRL_TWO, 8'h00);
		rd(ADDR_MODE_CTRL_TWO, v);
		chk(v & 32'h80, 32'h80, "fault kept after write");
		hstby <= 1'b1;
		cyc(3);
		hstby <= 1'b0;
		cyc(2);
		rdc(ADDR_MODE_CTRL_TWO, 8'h00, "two after hard standby");
		chk(fault, 1'b0, "fault cleared");
		rdc(ADDR_MODE_CTRL_ONE, 8'h80, "one after hard standby");
	endtask : t_fault

	// Both flash-disabled modes read zero and drop writes
	task automatic t_off();
		for (int m = 4; m <= 5; m++)
		begin
			mode <= m[3:0];
			cyc(2);
			rdc(ADDR_MODE_CTRL_ONE, 8'h00, "one while flash off");
			rdc(ADDR_MODE_CTRL_TWO, 8'h00, "two while flash off");
			wr8(ADDR_MODE_CTRL_ONE, 8'h40);
			mode <= 4'he;
			cyc(2);
			rdc(ADDR_MODE_CTRL_ONE, 8'h80, "write dropped while off");
		end
	endtask : t_off

	task automatic t_bus();
		wr(ADDR_MODE_CTRL_ONE, 32'h40, 4'hf, r);
		chk(r, RESP_SLVERR, "word write refused");
		wr(4'hc, 32'h0, 4'h1, r);
		chk(r, RESP_SLVERR, "unmapped write refused");
		rd(4'hc, v);
		chk(r, RESP_SLVERR, "unmapped read refused");
		sel <= 1'b0;
		wr8(ADDR_MODE_CTRL_ONE, 8'h40);
		sel <= 1'b1;
		rdc(ADDR_MODE_CTRL_ONE, 8'h80, "write dropped unselected");
	endtask : t_bus

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		cyc(20);
		rst_n <= 1'b1;
		cyc(2);
		t_gates();
		t_checks();
		t_go();
		t_protect();
		t_fault();
		t_off();
		t_bus();
		conclude();
	end

	// Whole run needs well under 2000 cycles; hang cut at 10000
	initial
	begin
		cyc(10000);
		err_count++;
		conclude();
	end

endmodule : flash_prog_erase_control_bench
